// [rtl/rpms_sequencer.sv]
// Reset, power-management and stop mode sequencer
//
// Notes on behaviour
// - In reset CPU and peripherals halt; on release fetch starts at 8000h.
// - Power-up reset lasts at least the power-on delay and while supply low.
// - Brownout holds reset until supply above reset level, then warmup delay; the code waits the power-on delay count (POR_CYC) instead.
// - Leaving power-on or brownout reset sets the power-on flag; software clears.
// - In stop mode a low reset pin forces reset at once, asynchronously.
// - Reset holds while pin low; released within four clocks of pin high.
// - Internal reset causes drive the reset pin low throughout the reset.
// - Watchdog timeout puts the device into reset.
// - Watchdog reset lasts four clocks with the pin driven low.
// - Watchdog reset sets the watchdog flag; only software clears it.
// - Software-triggered internal reset enters the same reset state.
// - Slow-clock enable gives one system clock per 256 oscillator clocks.
// - Writing slow-clock enable to 0 restores full rate; every reset clears it.
// - Setting slow-clock enable is ignored while any switchback source is active.
// - With switchback enabled, a switchback condition clears slow-clock enable.
// - Sources: external interrupt, receive falling edge, transmit buffer write.
// - Sources: SPI master write, SPI slave select, RTC alarms, debug entry.
// - Setting stop halts the CPU clock and system-clocked peripherals at once.
// - An enabled external interrupt wakes stop mode; execution then continues.
// - External reset in stop wakes into reset, then boots from 8000h.
// - Stop exit with ring select 0 warms main clock on ring, then switches.
// - Stop exit with ring select 1 stays on ring, main clock kept off.
// - Switchback detection runs on the undivided clock, without added latency.
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
module rpms_sequencer
   import rpms_pkg::*;
#(
   parameter int N_EXT_INT = 4,
   parameter int CLK_MHZ = 200,
   parameter int POR_DELAY_NS = 1000,
   parameter int POR_CYC = (POR_DELAY_NS * CLK_MHZ + 999) / 1000,
   parameter int WARMUP_CYC = 64,
   parameter int DIV_W = 8
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic por_ok,
   input wire logic supply_ok,
   input wire logic wdt_timeout,
   input wire logic rst_pin_in,
   output logic rst_pin_out,
   output logic rst_pin_oe,
   input wire logic [N_EXT_INT-1:0] ext_interrupt_pins,
   input wire logic [N_EXT_INT-1:0] ext_int_en,
   input wire logic serial_rx_pin,
   input wire logic spi_ssel_n_pin,
   input wire rpms_wake_t wake,
   input wire rpms_bus_t bus,
   output logic [15:0] rdata,
   output logic cpu_rst_n,
   output logic [15:0] boot_addr,
   output logic sys_clk_en,
   output logic main_clk_en,
   output logic ring_osc_en,
   output logic ext_wake
);
`include "rpms_consts.svh"
   localparam int SW = N_EXT_INT + 5;
   localparam logic [SW-1:0] SYNC_INIT = {5'b00111, {N_EXT_INT{1'b0}}};
   localparam logic [15:0] POR_LOAD = 16'(POR_CYC);
   localparam logic [15:0] WARM_LOAD = 16'(WARMUP_CYC);

   initial begin
      if (N_EXT_INT < 1 || DIV_W < 1 || POR_CYC < 1 || POR_CYC > 65535) begin
         $error("rpms_sequencer parameters out of range");
      end
      if (WARMUP_CYC < 1 || WARMUP_CYC > 65535) $error("rpms_sequencer warmup out of range");
   end

   logic [SW-1:0] pins_s;
   logic [N_EXT_INT-1:0] ext_s;
   logic rx_s, ssel_n_s, rst_pin_s, por_ok_s, supply_ok_s;
   rpms_sync2 #(.W(SW), .INIT(SYNC_INIT)) u_sync (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .d({por_ok, supply_ok, rst_pin_in, spi_ssel_n_pin, serial_rx_pin, ext_interrupt_pins}),
      .q(pins_s)
   );
   assign {por_ok_s, supply_ok_s, rst_pin_s, ssel_n_s, rx_s, ext_s} = pins_s;

   // Reset group state
   logic [2:0] ext_cnt_reg, ext_cnt_next;
   logic [2:0] int_cnt_reg, int_cnt_next;
   logic [15:0] por_cnt_reg, por_cnt_next;
   logic pwr_cause_reg, pwr_cause_next;
   logic pin_oe_reg, pin_oe_next;
   logic cpu_rst_n_reg, cpu_rst_n_next;
   logic ext_cause, pwr_cause, int_cause, any_cause;
   logic [1:0] oe_hist_reg, oe_hist_next;
   logic ext_mask;

   // Control group state
   logic slow_clock_enable_reg, slow_clock_enable_next, swb_reg, swb_next, ring_osc_select_reg, ring_osc_select_next, xtrc_reg, xtrc_next;
   logic por_flag_reg, por_flag_next, wdt_flag_reg, wdt_flag_next;
   logic [15:0] rdata_reg, rdata_next;
   rpms_clk_t clk_reg, clk_next;
   logic [15:0] warm_cnt_reg, warm_cnt_next;
   logic [DIV_W-1:0] div_reg, div_next;
   logic sys_en_reg, sys_en_next;
   logic rx_prev_reg;
   logic sb_active, ext_int_hit, wr_ctrl, wr_watchdog_control_reg, wr_cmd, stop_req, sw_req;

   assign wr_ctrl = bus.wr && bus.addr == `RPMS_ADDR_CTRL;
   assign wr_watchdog_control_reg = bus.wr && bus.addr == `RPMS_ADDR_WATCHDOG_CONTROL_REG;
   assign wr_cmd = bus.wr && bus.addr == `RPMS_ADDR_CMD;
   assign stop_req = wr_cmd && bus.wdata[`RPMS_CMD_STOP];
   assign sw_req = wr_cmd && bus.wdata[`RPMS_CMD_SWRST];
   assign ext_int_hit = |(ext_s & ext_int_en);

   // Switchback sources, all sampled on the undivided clock
   always_comb begin
      sb_active = ext_int_hit;
      sb_active |= rx_prev_reg && !rx_s && wake.uart_mode != 2'b00 && wake.uart_rx_en;
      sb_active |= wake.uart_tx_wr && wake.uart_tx_en;
      sb_active |= wake.spi_wr && wake.spi_master && wake.spi_tx_en;
      sb_active |= !ssel_n_s && !wake.spi_master;
      sb_active |= wake.rtc_tod_alarm && wake.rtc_tod_en;
      sb_active |= wake.rtc_sub_alarm && wake.rtc_sub_en;
      sb_active |= wake.debug_enter;
   end

   assign ext_cause = ext_cnt_reg == `RPMS_EXT_MIN_CYC;
   assign pwr_cause = !por_ok_s || !supply_ok_s || por_cnt_reg != 16'h0000;
   assign int_cause = int_cnt_reg != 3'h0;
   assign any_cause = ext_cause || pwr_cause || int_cause;
   // Own pin drive reaches the synchroniser late; not an outside request
   assign ext_mask = |oe_hist_reg;

   // Reset group next values
   always_comb begin
      ext_cnt_next = 3'h0;
      if (!rst_pin_s && !ext_mask) begin
         if (clk_reg == RPMS_CLK_STOP) begin
            ext_cnt_next = `RPMS_EXT_MIN_CYC;
         end else if (ext_cnt_reg != `RPMS_EXT_MIN_CYC) begin
            ext_cnt_next = ext_cnt_reg + 3'h1;
         end else begin
            ext_cnt_next = ext_cnt_reg;
         end
      end
      int_cnt_next = int_cnt_reg;
      if (wdt_timeout || (sw_req && cpu_rst_n_reg)) begin
         int_cnt_next = `RPMS_INT_RST_CYC;
      end else if (int_cause) begin
         int_cnt_next = int_cnt_reg - 3'h1;
      end
      por_cnt_next = por_cnt_reg;
      if (!por_ok_s || !supply_ok_s) begin
         por_cnt_next = POR_LOAD;
      end else if (por_cnt_reg != 16'h0000) begin
         por_cnt_next = por_cnt_reg - 16'h0001;
      end
      pwr_cause_next = pwr_cause;
      pin_oe_next = pwr_cause || int_cause || (wdt_timeout || (sw_req && cpu_rst_n_reg));
      oe_hist_next = {oe_hist_reg[0], pin_oe_reg};
      cpu_rst_n_next = !any_cause;
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ext_cnt_reg <= 3'h0;
         int_cnt_reg <= 3'h0;
         por_cnt_reg <= POR_LOAD;
         pwr_cause_reg <= 1'b1;
         pin_oe_reg <= 1'b1;
         oe_hist_reg <= 2'h3;
         cpu_rst_n_reg <= 1'b0;
      end else begin
         ext_cnt_reg <= ext_cnt_next;
         int_cnt_reg <= int_cnt_next;
         por_cnt_reg <= por_cnt_next;
         pwr_cause_reg <= pwr_cause_next;
         pin_oe_reg <= pin_oe_next;
         oe_hist_reg <= oe_hist_next;
         cpu_rst_n_reg <= cpu_rst_n_next;
      end
   end

   // Control, clock and register group next values
   always_comb begin
      slow_clock_enable_next = slow_clock_enable_reg;
      swb_next = swb_reg;
      ring_osc_select_next = ring_osc_select_reg;
      xtrc_next = xtrc_reg;
      if (wr_ctrl) begin
         swb_next = bus.wdata[`RPMS_CTRL_SWB];
         ring_osc_select_next = bus.wdata[`RPMS_CTRL_RING_OSC_SELECT];
         xtrc_next = bus.wdata[`RPMS_CTRL_XTRC];
         if (!bus.wdata[`RPMS_CTRL_SLOW_CLOCK_ENABLE]) begin
            slow_clock_enable_next = 1'b0;
         end else if (!sb_active) begin
            slow_clock_enable_next = 1'b1;
         end
      end
      if (swb_reg && slow_clock_enable_reg && sb_active) slow_clock_enable_next = 1'b0;
      if (any_cause) slow_clock_enable_next = 1'b0;
      por_flag_next = por_flag_reg;
      if (wr_watchdog_control_reg && !bus.wdata[`RPMS_WATCHDOG_CONTROL_REG_POR]) por_flag_next = 1'b0;
      if (pwr_cause_reg && !pwr_cause) por_flag_next = 1'b1;
      wdt_flag_next = wdt_flag_reg;
      if (wr_watchdog_control_reg && !bus.wdata[`RPMS_WATCHDOG_CONTROL_REG_WDT]) wdt_flag_next = 1'b0;
      if (wdt_timeout) wdt_flag_next = 1'b1;
      clk_next = clk_reg;
      warm_cnt_next = warm_cnt_reg;
      case (clk_reg)
         RPMS_CLK_MAIN: begin
            if (stop_req && !any_cause) clk_next = RPMS_CLK_STOP;
         end
         RPMS_CLK_STOP: begin
            if (any_cause || ext_int_hit) begin
               if (ring_osc_select_reg) begin
                  clk_next = RPMS_CLK_RING;
               end else begin
                  clk_next = RPMS_CLK_WARM;
                  warm_cnt_next = WARM_LOAD;
               end
            end
         end
         RPMS_CLK_WARM: begin
            if (warm_cnt_reg == 16'h0001) clk_next = RPMS_CLK_MAIN;
            warm_cnt_next = warm_cnt_reg - 16'h0001;
         end
         RPMS_CLK_RING: begin
            if (stop_req && !any_cause) clk_next = RPMS_CLK_STOP;
         end
         default: clk_next = RPMS_CLK_MAIN;
      endcase
      div_next = DIV_W'(div_reg + 1'b1);
      if (!slow_clock_enable_next) div_next = '0;
      sys_en_next = clk_next != RPMS_CLK_STOP && (!slow_clock_enable_next || div_next == '0);
      rdata_next = `RPMS_ZERO16;
      if (bus.rd) begin
         case (bus.addr)
            `RPMS_ADDR_CTRL: begin
               rdata_next[`RPMS_CTRL_SLOW_CLOCK_ENABLE] = slow_clock_enable_reg;
               rdata_next[`RPMS_CTRL_SWB] = swb_reg;
               rdata_next[`RPMS_CTRL_RING_OSC_SELECT] = ring_osc_select_reg;
               rdata_next[`RPMS_CTRL_XTRC] = xtrc_reg;
            end
            `RPMS_ADDR_WATCHDOG_CONTROL_REG: begin
               rdata_next[`RPMS_WATCHDOG_CONTROL_REG_POR] = por_flag_reg;
               rdata_next[`RPMS_WATCHDOG_CONTROL_REG_WDT] = wdt_flag_reg;
            end
            `RPMS_ADDR_STAT: begin
               rdata_next[`RPMS_STAT_RING_OSC_ACTIVE_STATUS] = clk_reg == RPMS_CLK_MAIN;
               rdata_next[`RPMS_STAT_STOP] = clk_reg == RPMS_CLK_STOP;
               rdata_next[`RPMS_STAT_RST] = !cpu_rst_n_reg;
               rdata_next[`RPMS_STAT_WARM] = clk_reg == RPMS_CLK_WARM;
            end
            default: rdata_next = `RPMS_ZERO16;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         slow_clock_enable_reg <= 1'b0;
         swb_reg <= 1'b0;
         ring_osc_select_reg <= 1'b0;
         xtrc_reg <= 1'b0;
         por_flag_reg <= 1'b0;
         wdt_flag_reg <= 1'b0;
         clk_reg <= RPMS_CLK_MAIN;
         warm_cnt_reg <= 16'h0000;
         div_reg <= '0;
         sys_en_reg <= 1'b0;
         rdata_reg <= `RPMS_ZERO16;
         rx_prev_reg <= 1'b1;
      end else begin
         slow_clock_enable_reg <= slow_clock_enable_next;
         swb_reg <= swb_next;
         ring_osc_select_reg <= ring_osc_select_next;
         xtrc_reg <= xtrc_next;
         por_flag_reg <= por_flag_next;
         wdt_flag_reg <= wdt_flag_next;
         clk_reg <= clk_next;
         warm_cnt_reg <= warm_cnt_next;
         div_reg <= div_next;
         sys_en_reg <= sys_en_next;
         rdata_reg <= rdata_next;
         rx_prev_reg <= rx_s;
      end
   end

   // Outputs; the stop-mode pin path bypasses the clock
   assign cpu_rst_n = cpu_rst_n_reg && !(clk_reg == RPMS_CLK_STOP && !rst_pin_in);
   assign rst_pin_out = 1'b0;
   assign rst_pin_oe = pin_oe_reg;
   assign boot_addr = `RPMS_BOOT_ADDR;
   assign sys_clk_en = sys_en_reg;
   assign main_clk_en = clk_reg == RPMS_CLK_MAIN || (clk_reg == RPMS_CLK_WARM);
   assign ring_osc_en = clk_reg == RPMS_CLK_WARM || clk_reg == RPMS_CLK_RING;
   assign ext_wake = clk_reg == RPMS_CLK_STOP && ext_int_hit;
   assign rdata = rdata_reg;

   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   a_ext_min_low: assert property (
      $fell(rst_pin_s) && !ext_mask && clk_reg != RPMS_CLK_STOP
      ##1 (!rst_pin_s && !ext_mask) [*3] |=> ##1 !cpu_rst_n_reg)
      else $error("pin low four clocks did not reset");
   a_ext_release: assert property (
      $rose(rst_pin_in) && !pwr_cause && !int_cause ##1 rst_pin_in [*4] |-> cpu_rst_n_reg
      || pwr_cause || int_cause)
      else $error("reset not released four clocks after pin high");
   a_wdt_length: assert property (
      wdt_timeout && !pwr_cause && ext_cnt_reg == 3'h0 && rst_pin_s |=> ##1 (!cpu_rst_n_reg
      && rst_pin_oe) [*4])
      else $error("watchdog reset shorter than four clocks");
   a_wdt_flag_set: assert property (
      wdt_timeout |=> wdt_flag_reg)
      else $error("watchdog flag not set");
   a_por_flag_set: assert property (
      $fell(pwr_cause) |=> por_flag_reg)
      else $error("power-on flag not set on exit");
   a_slow_clock_enable_reset: assert property (
      any_cause |=> !slow_clock_enable_reg)
      else $error("slow clock enable survived reset");
   a_slow_clock_enable_blocked: assert property (
      wr_ctrl && bus.wdata[`RPMS_CTRL_SLOW_CLOCK_ENABLE] && sb_active && !slow_clock_enable_reg |=> !slow_clock_enable_reg)
      else $error("slow clock set while switchback source active");
   a_switchback: assert property (
      swb_reg && slow_clock_enable_reg && sb_active |=> !slow_clock_enable_reg && (sys_clk_en || clk_reg == RPMS_CLK_STOP))
      else $error("switchback did not restore full rate");
   a_slow_rate: assert property (
      slow_clock_enable_reg && $past(slow_clock_enable_reg) && sys_en_reg && clk_reg != RPMS_CLK_STOP |=>
      !sys_en_reg || !slow_clock_enable_reg)
      else $error("slow clock enable too frequent");
   a_stop_halt: assert property (
      stop_req && !any_cause && clk_reg == RPMS_CLK_MAIN |=> !sys_clk_en && !main_clk_en)
      else $error("stop did not halt clocks");
   a_stop_wake: assert property (
      clk_reg == RPMS_CLK_STOP && ext_int_hit |=> ring_osc_en && (main_clk_en == !ring_osc_select_reg))
      else $error("stop exit clocking wrong");
   a_stop_pin_async: assert property (
      clk_reg == RPMS_CLK_STOP && !rst_pin_in ##1 !rst_pin_in [*2] |-> !cpu_rst_n ##[1:2]
      !cpu_rst_n_reg)
      else $error("pin low in stop did not reset at once");

   c_watchdog: cover property (wdt_timeout ##[1:8] cpu_rst_n_reg);
   c_switchback: cover property (slow_clock_enable_reg && swb_reg ##1 !slow_clock_enable_reg);
   c_stop_warm: cover property (clk_reg == RPMS_CLK_STOP ##1 clk_reg == RPMS_CLK_WARM);
   c_ext_reset: cover property (ext_cause ##1 !ext_cause);
endmodule : rpms_sequencer

// [rtl/rpms_consts.svh]
// Constants for the reset, power and mode sequencer
`ifndef RPMS_CONSTS_SVH
`define RPMS_CONSTS_SVH
`define RPMS_ADDR_CTRL 8'h00
`define RPMS_ADDR_WATCHDOG_CONTROL_REG 8'h04
`define RPMS_ADDR_STAT 8'h08
`define RPMS_ADDR_CMD 8'h0C
`define RPMS_CTRL_SLOW_CLOCK_ENABLE 0
`define RPMS_CTRL_SWB 1
`define RPMS_CTRL_RING_OSC_SELECT 2
`define RPMS_CTRL_XTRC 3
`define RPMS_WATCHDOG_CONTROL_REG_POR 0
`define RPMS_WATCHDOG_CONTROL_REG_WDT 1
`define RPMS_STAT_RING_OSC_ACTIVE_STATUS 0
`define RPMS_STAT_STOP 1
`define RPMS_STAT_RST 2
`define RPMS_STAT_WARM 3
`define RPMS_CMD_STOP 0
`define RPMS_CMD_SWRST 1
`define RPMS_BOOT_ADDR 16'h8000
`define RPMS_EXT_MIN_CYC 3'h4
`define RPMS_INT_RST_CYC 3'h4
`define RPMS_ZERO16 16'h0000
`endif

// [rtl/rpms_pkg.sv]
// Types for the reset, power and mode sequencer
package rpms_pkg;
   typedef struct packed {
      logic [7:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } rpms_bus_t;
   typedef struct packed {
      logic uart_rx_en;
      logic [1:0] uart_mode;
      logic uart_tx_en;
      logic uart_tx_wr;
      logic spi_master;
      logic spi_tx_en;
      logic spi_wr;
      logic rtc_tod_alarm;
      logic rtc_tod_en;
      logic rtc_sub_alarm;
      logic rtc_sub_en;
      logic debug_enter;
   } rpms_wake_t;
   typedef enum logic [1:0] {RPMS_CLK_MAIN, RPMS_CLK_STOP, RPMS_CLK_WARM, RPMS_CLK_RING} rpms_clk_t;
endpackage : rpms_pkg

// [rtl/rpms_sync2.sv]
// Two-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
module rpms_sync2 #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] q_reg;
   initial begin
      if (W < 1) $error("rpms_sync2 width must be positive");
   end
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= INIT;
         q_reg <= INIT;
      end else begin
         meta_reg <= d;
         q_reg <= meta_reg;
      end
   end
   assign q = q_reg;
endmodule : rpms_sync2

// [verif/rpms_far_side.sv]
// Far-side model: reset pin driver and wake-up sources
`timescale 1ns/1ps
module rpms_far_side #(
   parameter int N = 4
) (
   input wire logic sys_clk,
   input wire logic rst_pin_oe,
   input wire logic rst_pin_out,
   output logic rst_pin_in,
   output logic [N-1:0] int_pins,
   output logic rx_pin,
   output logic ssel_n
);
   logic drv;
   initial begin
      drv = 1'b1;
      int_pins = '0;
      rx_pin = 1'b1;
      ssel_n = 1'b1;
   end
   // Open-drain pin with pull-up: low while either side pulls
   assign rst_pin_in = drv & ~(rst_pin_oe & ~rst_pin_out);
   task automatic pin(input logic v);
      drv <= v;
   endtask : pin
   // Reset request never shorter than four clocks
   task automatic press(input int k);
      drv <= 1'b0;
      repeat ((k < 4) ? 4 : k) @(posedge sys_clk);
      drv <= 1'b1;
   endtask : press
   task automatic irq(input int i, input logic v);
      int_pins[i] <= v;
   endtask : irq
   task automatic rx(input logic v);
      rx_pin <= v;
   endtask : rx
   task automatic ssel(input logic v);
      ssel_n <= v;
   endtask : ssel
endmodule : rpms_far_side

// [verif/rpms_sequencer_test.sv]
// Self-checking bench for the reset, power and mode sequencer
`timescale 1ns/1ps
`include "rpms_consts.svh"
module rpms_sequencer_test
   import rpms_pkg::*;
;
   logic sys_clk, rst_n, por_ok, supply_ok, wdt_timeout, rst_pin_in, rst_pin_out, rst_pin_oe;
   logic rx_pin, ssel_n, cpu_rst_n, sys_clk_en, main_clk_en, ring_osc_en, ext_wake;
   logic [3:0] int_pins, int_en;
   logic [15:0] rdata, boot_addr;
   rpms_wake_t wake;
   rpms_bus_t bus;
   int fails, comparisons, exp_ctrl, n, low, bad, pin_sel;
   logic [12:0] srcmask [10] = '{13'h0000, 13'h1000, 13'h1000, 13'h1000, 13'h0300,
      13'h00E0, 13'h0000, 13'h0018, 13'h0006, 13'h0001};
   rpms_sequencer #(.POR_DELAY_NS(20), .WARMUP_CYC(4)) dut (
      .sys_clk(sys_clk), .rst_n(rst_n), .por_ok(por_ok), .supply_ok(supply_ok),
      .wdt_timeout(wdt_timeout), .rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out),
      .rst_pin_oe(rst_pin_oe), .ext_interrupt_pins(int_pins), .ext_int_en(int_en),
      .serial_rx_pin(rx_pin), .spi_ssel_n_pin(ssel_n), .wake(wake), .bus(bus),
      .rdata(rdata), .cpu_rst_n(cpu_rst_n), .boot_addr(boot_addr), .sys_clk_en(sys_clk_en),
      .main_clk_en(main_clk_en), .ring_osc_en(ring_osc_en), .ext_wake(ext_wake));
   rpms_far_side #(.N(4)) far (
      .sys_clk(sys_clk), .rst_pin_oe(rst_pin_oe), .rst_pin_out(rst_pin_out),
      .rst_pin_in(rst_pin_in), .int_pins(int_pins), .rx_pin(rx_pin), .ssel_n(ssel_n));
   always #2.5 sys_clk = ~sys_clk;
   task automatic results();
      if (fails == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : results
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic tick(input int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask : tick
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      @(posedge sys_clk);
      bus.wr <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [15:0] e, input string nm);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge sys_clk);
      bus.rd <= 1'b0;
      #1 chk(nm, e, rdata);
   endtask : rd
   task automatic wait_hi(input logic w, input int b);
      n = 0;
      while ((w ? sys_clk_en : cpu_rst_n) !== 1'b1) begin
         tick(1);
         n++;
         if (n > b) begin
            chk("timeout", 16'h0000, 16'h0001);
            results();
         end
      end
   endtask : wait_hi
   task automatic measure();
      low = 0;
      bad = 0;
      repeat (12) begin
         tick(1);
         low += (cpu_rst_n === 1'b0);
         bad += (cpu_rst_n === 1'b0 && rst_pin_oe !== 1'b1);
      end
   endtask : measure
   // Sources 0 ext int, 1-3 receive in mode 1-3, 4 tx, 5 spi master, 6 ssel, 7-8 rtc, 9 debug
   task automatic source(input int i, input logic v);
      wake <= v ? rpms_wake_t'(srcmask[i] | 13'((i % 4) << 10)) : rpms_wake_t'(13'h0000);
      if (i == 0) far.irq(pin_sel, v);
      if (i >= 1 && i <= 3) far.rx(~v);
      if (i == 6) far.ssel(~v);
   endtask : source
   initial begin
      void'($urandom(91));
      sys_clk = 1'b0;
      rst_n = 1'b0;
      por_ok = 1'b0;
      supply_ok = 1'b1;
      wdt_timeout = 1'b0;
      int_en = '0;
      wake = '0;
      bus = '0;
      fails = 0;
      comparisons = 0;
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'b1;
      tick(20);
      chk("cpu_rst_n por", 16'h0000, 16'(cpu_rst_n));
      por_ok <= 1'b1;
      wait_hi(1'b0, 40);
      chk("boot_addr", `RPMS_BOOT_ADDR, boot_addr);
      rd(`RPMS_ADDR_WATCHDOG_CONTROL_REG, 16'h0001, "por flag");
      wr(`RPMS_ADDR_WATCHDOG_CONTROL_REG, 16'h0000);
      rd(`RPMS_ADDR_WATCHDOG_CONTROL_REG, 16'h0000, "por flag clear");
      rd(8'h20, 16'h0000, "unmapped");
      wr(`RPMS_ADDR_CTRL, 16'h0001);
      wdt_timeout <= 1'b1;
      tick(1);
      wdt_timeout <= 1'b0;
      measure();
      chk("wdt reset cycles", 16'h0004, 16'(low));
      chk("wdt pin drive", 16'h0000, 16'(bad));
      rd(`RPMS_ADDR_WATCHDOG_CONTROL_REG, 16'h0002, "wdt flag");
      rd(`RPMS_ADDR_CTRL, 16'h0000, "slow after reset");
      wr(`RPMS_ADDR_CMD, 16'h0002);
      measure();
      chk("sw reset cycles", 16'h0004, 16'(low));
      chk("sw pin drive", 16'h0000, 16'(bad));
      far.pin(1'b0);
      tick(3);
      far.pin(1'b1);
      measure();
      chk("short pin pulse", 16'h0000, 16'(low));
      far.press(8);
      #1 chk("ext reset", 16'h0000, 16'(cpu_rst_n));
      wait_hi(1'b0, 12);
      chk("ext release", 16'h0001, 16'(n <= 4));
      wr(`RPMS_ADDR_CTRL, 16'h0001);
      low = 0;
      repeat (512) begin
         tick(1);
         low += (sys_clk_en === 1'b1);
      end
      chk("slow rate", 16'h0002, 16'(low));
      wr(`RPMS_ADDR_CTRL, 16'h0000);
      tick(2);
      low = 0;
      repeat (4) begin
         tick(1);
         low += (sys_clk_en === 1'b1);
      end
      chk("full rate", 16'h0004, 16'(low));
      pin_sel = $urandom_range(3);
      int_en <= 4'(1 << pin_sel);
      for (int i = 0; i < 10; i++) begin
         exp_ctrl = 3 | ($urandom_range(1) << 3);
         wr(`RPMS_ADDR_CTRL, 16'(exp_ctrl));
         rd(`RPMS_ADDR_CTRL, 16'(exp_ctrl), "slow armed");
         source(i, 1'b1);
         tick(6);
         source(i, 1'b0);
         tick(2);
         exp_ctrl = exp_ctrl & 14;
         rd(`RPMS_ADDR_CTRL, 16'(exp_ctrl), "switchback");
      end
      source(7, 1'b1);
      tick(1);
      wr(`RPMS_ADDR_CTRL, 16'(exp_ctrl | 1));
      rd(`RPMS_ADDR_CTRL, 16'(exp_ctrl), "slow refused");
      source(7, 1'b0);
      wr(`RPMS_ADDR_CTRL, 16'h0004);
      wr(`RPMS_ADDR_CMD, 16'h0001);
      tick(2);
      chk("stop clocks", 16'h0000, 16'({sys_clk_en, main_clk_en}));
      far.irq((pin_sel + 1) % 4, 1'b1);
      tick(4);
      chk("masked irq", 16'h0000, 16'({sys_clk_en, ext_wake}));
      far.irq((pin_sel + 1) % 4, 1'b0);
      tick(1);
      far.irq(pin_sel, 1'b1);
      tick(2);
      chk("wake request", 16'h0001, 16'(ext_wake));
      wait_hi(1'b1, 20);
      far.irq(pin_sel, 1'b0);
      chk("ring resume", 16'h0002 >> 1, 16'({main_clk_en, ring_osc_en}));
      wr(`RPMS_ADDR_CTRL, 16'h0000);
      wr(`RPMS_ADDR_CMD, 16'h0001);
      tick(2);
      far.irq(pin_sel, 1'b1);
      wait_hi(1'b1, 20);
      far.irq(pin_sel, 1'b0);
      chk("warmup", 16'h0003, 16'({main_clk_en, ring_osc_en}));
      tick(8);
      chk("main clock", 16'h0002, 16'({main_clk_en, ring_osc_en}));
      rd(`RPMS_ADDR_STAT, 16'h0001, "ring status");
      wr(`RPMS_ADDR_CMD, 16'h0001);
      tick(2);
      far.pin(1'b0);
      #1 chk("stop pin reset", 16'h0000, 16'(cpu_rst_n));
      tick(5);
      far.pin(1'b1);
      wait_hi(1'b0, 12);
      chk("boot after stop", `RPMS_BOOT_ADDR, boot_addr);
      supply_ok <= 1'b0;
      tick(6);
      chk("brownout", 16'h0001, 16'({cpu_rst_n, rst_pin_oe}));
      supply_ok <= 1'b1;
      wait_hi(1'b0, 40);
      rd(`RPMS_ADDR_WATCHDOG_CONTROL_REG, 16'h0003, "flags after brownout");
      results();
   end
endmodule : rpms_sequencer_test
